// [hw/baud_pkg.sv]
// Purpose: shared constants and types for the two serial baud rate generators
// Assumes: apb slave with 32-bit data, one register per aligned word
// Notes: printed offsets are word indices; the byte address is four times the index
// Functional notes
// (R01) shift clock: generator output or raw clock
// (R02) source bit lives in async/sync mode registers
// (R03) transmit and receive share one shift clock
// (R04) prescaler, 8-bit timer, compare register per channel
// (R05) system clock is the only generator input
// (R06) uart rate is clock over 2*j*2^k*16*2
// (R07) csi rate is clock over 2*j*2^k*2
// (R08) compare range 1..256, zero means 256
// (R09) prescaler exponent limited to 0..4
// (R10) compare register 8 bits, read/write
// (R11) compare write clears timer; avoid mid-transfer
// (R12) enable bit 7; zero stops and clears
// (R13) select bits 2..0 pick clock/2 to /32
// (R14) software keeps prescale select during transfers
// (R15) software keeps rate error within 2.3 percent
// (R16) timer match clears timer and toggles output
package baud_pkg;
  localparam int CHANNELS = 2;
  localparam logic [CHANNELS-1:0][31:0] PRESCALE_IDX = {32'hfffff096, 32'hfffff086};
  localparam logic [CHANNELS-1:0][31:0] COMPARE_IDX = {32'hfffff094, 32'hfffff084};
  localparam logic [CHANNELS-1:0][31:0] ASYNC_MODE_IDX = {32'hfffff0a4, 32'hfffff0a0};
  localparam logic [CHANNELS-1:0][31:0] SYNC_MODE_IDX = {32'hfffff0ac, 32'hfffff0a8};
  localparam logic [CHANNELS-1:0][31:0] STATUS_IDX = {32'hfffff0b4, 32'hfffff0b0};
  localparam int COUNT_ENABLE_BIT = 7;
  localparam int PRESCALE_SEL_MSB = 2;
  localparam int SRC_SEL_BIT = 0;
  localparam logic [7:0] PRESCALE_RW_MASK = 8'h87;
  localparam logic [7:0] PRESCALE_RST = 8'h00;
  localparam logic [7:0] COMPARE_RST = 8'h00;
  localparam logic MODE_SRC_RST = 1'h0;
  localparam logic [2:0] PRESCALE_MAX_EXP = 3'h4;

  function automatic logic [31:0] byte_addr(input logic [31:0] idx);
    return {idx[29:0], 2'h0};
  endfunction

  typedef enum logic [1:0] {
    GEN_STOPPED = 2'h1,
    GEN_RUNNING = 2'h2
  } gen_phase_t;

  typedef struct packed {
    logic enable;
    logic [2:0] sel;
    logic [7:0] cmp;
    logic cmp_wr;
  } gen_cfg_t;

  typedef struct packed {
    gen_phase_t phase;
    logic [4:0] presc;
    logic [7:0] timer;
    logic level;
    logic tick;
  } gen_state_t;

  typedef struct packed {
    logic tick;
  } select_state_t;

  typedef struct packed {
    logic uart_tick;
    logic csi_tick;
    logic rate_level;
  } shift_clk_t;

  typedef struct packed {
    logic [CHANNELS-1:0][7:0] prescale;
    logic [CHANNELS-1:0][7:0] compare;
    logic [CHANNELS-1:0] async_src;
    logic [CHANNELS-1:0] sync_src;
    logic [31:0] rdata;
  } regs_state_t;
endpackage

// [hw/rate_generator_inst.sv]
// Purpose: one baud rate generator: prescaler, 8-bit timer, toggling output
// Assumes: configuration comes straight from software registers
// Notes: tick is a one-cycle pulse on every output toggle
`timescale 1ns/1ps
module rate_generator_inst (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // configuration
  input wire baud_pkg::gen_cfg_t cfg,
  // state and generated clock
  output baud_pkg::gen_state_t stat
);
  import baud_pkg::*;

  gen_state_t st_reg;
  gen_state_t st_next;
  logic [2:0] exp;
  logic [4:0] mask;

  assign stat = st_reg;

  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'h0;
    // anything at or above four means clock/32
    exp = cfg.sel[PRESCALE_SEL_MSB] ? PRESCALE_MAX_EXP : {1'h0, cfg.sel[1:0]}; // [R09] [R13]
    mask = 5'((6'h2 << exp) - 6'h1); // [R13]
    case (st_reg.phase)
      GEN_STOPPED: begin
        st_next.presc = 5'h0; // [R12]
        st_next.timer = 8'h0;
        st_next.level = 1'h0;
        if (cfg.enable) begin
          st_next.phase = GEN_RUNNING;
        end
      end
      GEN_RUNNING: begin
        if (!cfg.enable) begin
          st_next.phase = GEN_STOPPED; // [R12]
          st_next.presc = 5'h0;
          st_next.timer = 8'h0;
          st_next.level = 1'h0;
        end else begin
          st_next.presc = st_reg.presc + 5'h1; // [R05]
          if ((st_reg.presc & mask) == mask) begin
            // a stored zero wraps to 255 here, giving a count of 256
            if (st_reg.timer == cfg.cmp - 8'h1) begin // [R08]
              st_next.timer = 8'h0; // [R16]
              st_next.level = ~st_reg.level;
              st_next.tick = 1'h1;
            end else begin
              st_next.timer = st_reg.timer + 8'h1; // [R04]
            end
          end
        end
      end
      default: begin
        st_next = '{phase: GEN_STOPPED, default: '0};
      end
    endcase
    if (cfg.cmp_wr) begin
      st_next.timer = 8'h0; // [R11]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '{phase: GEN_STOPPED, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

// [hw/source_clock_select.sv]
// Purpose: picks the shift clock source for one serial unit
// Assumes: generator tick is a registered one-cycle pulse
// Notes: raw system clock appears as a tick on every cycle
`timescale 1ns/1ps
module source_clock_select (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // source choice
  input wire logic use_gen,
  input wire logic gen_tick,
  // selected shift clock
  output logic tick
);
  import baud_pkg::*;

  select_state_t st_reg;
  select_state_t st_next;

  assign tick = st_reg.tick;

  always_comb begin
    st_next.tick = use_gen ? gen_tick : 1'h1; // [R01]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

// [hw/serial_baud_rate_generator.sv]
// Purpose: two baud rate generators with their apb register file
// Assumes: zero-wait apb slave, 8-bit registers in byte lane 0, status level read in bit 8
// Notes: each channel feeds an async and a clocked serial unit
`timescale 1ns/1ps
module serial_baud_rate_generator (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // shift clocks to the serial units
  output baud_pkg::shift_clk_t [baud_pkg::CHANNELS-1:0] shift_clk
);
  import baud_pkg::*;

  regs_state_t st_reg;
  regs_state_t st_next;
  logic hit;
  logic [31:0] rval;
  logic access;
  logic wr_lane0;
  logic [CHANNELS-1:0] wr_prescale;
  logic [CHANNELS-1:0] wr_compare;
  gen_cfg_t [CHANNELS-1:0] gen_cfg;
  gen_state_t [CHANNELS-1:0] gen_stat;

  // never stalls: every access finishes in its first access cycle
  assign pready = 1'h1;
  assign access = psel && penable;
  assign wr_lane0 = access && pwrite && pstrb[0];
  assign pslverr = access && !hit;
  assign prdata = st_reg.rdata;

  // address decode and read mux
  always_comb begin
    hit = 1'h0;
    rval = 32'h0;
    for (int c = 0; c < CHANNELS; c++) begin
      if (paddr == byte_addr(PRESCALE_IDX[c])) begin
        hit = 1'h1;
        // bits 6..3 are not stored and read zero
        rval = {24'h0, st_reg.prescale[c] & PRESCALE_RW_MASK};
      end
      if (paddr == byte_addr(COMPARE_IDX[c])) begin
        hit = 1'h1;
        rval = {24'h0, st_reg.compare[c]}; // [R10]
      end
      if (paddr == byte_addr(ASYNC_MODE_IDX[c])) begin
        hit = 1'h1;
        rval = 32'(st_reg.async_src[c]) << SRC_SEL_BIT;
      end
      if (paddr == byte_addr(SYNC_MODE_IDX[c])) begin
        hit = 1'h1;
        rval = 32'(st_reg.sync_src[c]) << SRC_SEL_BIT;
      end
      if (paddr == byte_addr(STATUS_IDX[c])) begin
        hit = 1'h1;
        rval = {23'h0, gen_stat[c].level, gen_stat[c].timer};
      end
    end
  end

  // register writes and read capture
  always_comb begin
    st_next = st_reg;
    wr_prescale = '0;
    wr_compare = '0;
    if (psel && !penable && !pwrite) begin
      // read data is captured in setup so it leaves a flip-flop
      st_next.rdata = rval;
    end
    for (int c = 0; c < CHANNELS; c++) begin
      if (wr_lane0 && paddr == byte_addr(PRESCALE_IDX[c])) begin
        wr_prescale[c] = 1'h1;
        st_next.prescale[c] = pwdata[7:0] & PRESCALE_RW_MASK; // [R12] [R13]
      end
      if (wr_lane0 && paddr == byte_addr(COMPARE_IDX[c])) begin
        wr_compare[c] = 1'h1;
        st_next.compare[c] = pwdata[7:0]; // [R10]
      end
      if (wr_lane0 && paddr == byte_addr(ASYNC_MODE_IDX[c])) begin
        st_next.async_src[c] = pwdata[SRC_SEL_BIT]; // [R02]
      end
      if (wr_lane0 && paddr == byte_addr(SYNC_MODE_IDX[c])) begin
        st_next.sync_src[c] = pwdata[SRC_SEL_BIT]; // [R02]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg.prescale <= {CHANNELS{PRESCALE_RST}};
      st_reg.compare <= {CHANNELS{COMPARE_RST}};
      st_reg.async_src <= {CHANNELS{MODE_SRC_RST}};
      st_reg.sync_src <= {CHANNELS{MODE_SRC_RST}};
      st_reg.rdata <= 32'h0;
    end else begin
      st_reg <= st_next;
    end
  end

  // apb phases shared by the checks below
  sequence s_setup_write;
    psel && !penable && pwrite;
  endsequence

  sequence s_access_done;
    psel && penable && pready;
  endsequence

  sequence s_setup_read;
    psel && !penable && !pwrite;
  endsequence

  chk_unmapped_error: assert property (
    @(posedge pclk) disable iff (!presetn)
    (s_access_done and (!hit)) |-> pslverr
  ) else $error("unmapped access without pslverr");

  chk_read_upper_zero: assert property ( // [R10]
    @(posedge pclk) disable iff (!presetn)
    s_setup_read |=> prdata[31:9] == 23'h0
  ) else $error("read data shows bits above the register");

  genvar c;
  generate
    for (c = 0; c < CHANNELS; c++) begin : g_ch
      logic [13:0] gap_reg;
      logic [1:0] dirty_reg;
      logic [8:0] span;
      logic [2:0] exp_chk;
      logic [13:0] expect_gap;

      assign gen_cfg[c].enable = st_reg.prescale[c][COUNT_ENABLE_BIT]; // [R12]
      assign gen_cfg[c].sel = st_reg.prescale[c][PRESCALE_SEL_MSB:0]; // [R13]
      assign gen_cfg[c].cmp = st_reg.compare[c];
      assign gen_cfg[c].cmp_wr = wr_compare[c]; // [R11]

      // one generator per channel, clocked by the system clock only
      rate_generator_inst u_gen ( // [R04] [R05]
        .pclk(pclk),
        .presetn(presetn),
        .cfg(gen_cfg[c]),
        .stat(gen_stat[c])
      );

      // the async unit oversamples by sixteen on this tick
      source_clock_select u_uart_src ( // [R06]
        .pclk(pclk),
        .presetn(presetn),
        .use_gen(st_reg.async_src[c]),
        .gen_tick(gen_stat[c].tick), // [R03]
        .tick(shift_clk[c].uart_tick)
      );

      // the clocked unit shifts on this tick without oversampling
      source_clock_select u_csi_src ( // [R07]
        .pclk(pclk),
        .presetn(presetn),
        .use_gen(st_reg.sync_src[c]),
        .gen_tick(gen_stat[c].tick), // [R03]
        .tick(shift_clk[c].csi_tick)
      );

      assign shift_clk[c].rate_level = gen_stat[c].level; // [R16]

      // helper: cycles between ticks, and whether settings moved since
      assign span = (st_reg.compare[c] == 8'h0) ? 9'h100 : {1'h0, st_reg.compare[c]};
      assign exp_chk = gen_cfg[c].sel[PRESCALE_SEL_MSB] ? PRESCALE_MAX_EXP
                                                       : {1'h0, gen_cfg[c].sel[1:0]};
      assign expect_gap = 14'(span) << (exp_chk + 3'h1);

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          gap_reg <= 14'h0;
          dirty_reg <= 2'h2;
        end else begin
          gap_reg <= gen_stat[c].tick ? 14'h1 : gap_reg + 14'h1;
          if (wr_prescale[c] || wr_compare[c] || !gen_cfg[c].enable) begin
            // a tick already launched at the write edge uses up one of the two skips
            dirty_reg <= 2'h2;
          end else if (gen_stat[c].tick && dirty_reg != 2'h0) begin
            dirty_reg <= dirty_reg - 2'h1;
          end
        end
      end

      chk_src_raw_clock: assert property ( // [R01]
        @(posedge pclk) disable iff (!presetn)
        !st_reg.async_src[c] |=> shift_clk[c].uart_tick
      ) else $error("raw clock source gave no tick");

      chk_src_generator: assert property ( // [R02]
        @(posedge pclk) disable iff (!presetn)
        st_reg.sync_src[c]
        |=> shift_clk[c].csi_tick == $past(gen_stat[c].tick)
      ) else $error("csi tick does not follow generator");

      chk_shared_tick: assert property ( // [R03]
        @(posedge pclk) disable iff (!presetn)
        (st_reg.async_src[c] && st_reg.sync_src[c])
        |=> shift_clk[c].uart_tick == shift_clk[c].csi_tick
      ) else $error("uart and csi ticks differ on shared source");

      chk_cmp_clears_timer: assert property ( // [R11]
        @(posedge pclk) disable iff (!presetn)
        (s_setup_write
         ##1 (s_access_done and (paddr == byte_addr(COMPARE_IDX[c]))
              and pstrb[0]))
        |=> gen_stat[c].timer == 8'h0
      ) else $error("compare write left timer running");

      chk_stop_holds_clear: assert property ( // [R12]
        @(posedge pclk) disable iff (!presetn)
        (!gen_cfg[c].enable)[*2]
        |-> (gen_stat[c].timer == 8'h0) && !gen_stat[c].level
            && !gen_stat[c].tick
      ) else $error("stopped generator not held clear");

      chk_tick_period: assert property ( // [R13]
        @(posedge pclk) disable iff (!presetn)
        (gen_stat[c].tick && dirty_reg == 2'h0) |-> gap_reg == expect_gap
      ) else $error("tick spacing differs from compare and prescale");

      chk_timer_bounded: assert property ( // [R08]
        @(posedge pclk) disable iff (!presetn)
        (st_reg.compare[c] != 8'h0 && dirty_reg == 2'h0)
        |-> gen_stat[c].timer < st_reg.compare[c]
      ) else $error("timer passed its compare value");

      chk_toggle_on_tick: assert property ( // [R16]
        @(posedge pclk) disable iff (!presetn)
        $changed(gen_stat[c].level) && gen_cfg[c].enable
        |-> gen_stat[c].tick && gen_stat[c].timer == 8'h0
      ) else $error("output toggled without a timer match");

      chk_compare_write: assert property ( // [R10]
        @(posedge pclk) disable iff (!presetn)
        (s_access_done and pwrite and pstrb[0]
         and (paddr == byte_addr(COMPARE_IDX[c])))
        |=> st_reg.compare[c] == $past(pwdata[7:0])
      ) else $error("compare register did not take written byte");

      chk_prescale_readback: assert property ( // [R09]
        @(posedge pclk) disable iff (!presetn)
        (s_setup_read and (paddr == byte_addr(PRESCALE_IDX[c])))
        |=> prdata[31:8] == 24'h0 && prdata[6:3] == 4'h0
            && prdata[2:0] == st_reg.prescale[c][2:0]
      ) else $error("prescale readback shows unused bits");

      chk_compare_readback: assert property ( // [R10]
        @(posedge pclk) disable iff (!presetn)
        (s_setup_read and (paddr == byte_addr(COMPARE_IDX[c])))
        |=> prdata == {24'h0, st_reg.compare[c]}
      ) else $error("compare readback differs from register");

      chk_strobe_ignored: assert property ( // [R10]
        @(posedge pclk) disable iff (!presetn)
        (s_access_done and pwrite and !pstrb[0]
         and (paddr == byte_addr(COMPARE_IDX[c])))
        |=> $stable(st_reg.compare[c])
      ) else $error("write without lane 0 changed compare");

      chk_prescale_write: assert property ( // [R13]
        @(posedge pclk) disable iff (!presetn)
        (s_access_done and pwrite and pstrb[0]
         and (paddr == byte_addr(PRESCALE_IDX[c])))
        |=> st_reg.prescale[c] == ($past(pwdata[7:0]) & PRESCALE_RW_MASK)
      ) else $error("prescale register did not take masked byte");

      chk_unused_bits_zero: assert property ( // [R12]
        @(posedge pclk) disable iff (!presetn)
        st_reg.prescale[c][6:3] == 4'h0
      ) else $error("prescale bits 6..3 hold a value");

      chk_enable_starts: assert property ( // [R12]
        @(posedge pclk) disable iff (!presetn)
        $rose(gen_cfg[c].enable) |=> gen_stat[c].phase == GEN_RUNNING
      ) else $error("generator did not start on enable");

      chk_prescaler_counts: assert property ( // [R05]
        @(posedge pclk) disable iff (!presetn)
        (gen_stat[c].phase == GEN_RUNNING && gen_cfg[c].enable)
        |=> gen_stat[c].presc == $past(gen_stat[c].presc) + 5'h1
      ) else $error("prescaler skipped a system clock");

      chk_stop_presc_clear: assert property ( // [R12]
        @(posedge pclk) disable iff (!presetn)
        !gen_cfg[c].enable |=> gen_stat[c].presc == 5'h0
            && gen_stat[c].phase == GEN_STOPPED
      ) else $error("stopped generator kept its prescaler");

      chk_timer_steps: assert property ( // [R04]
        @(posedge pclk) disable iff (!presetn)
        gen_cfg[c].enable
        |=> gen_stat[c].timer == 8'h0
            || gen_stat[c].timer == $past(gen_stat[c].timer)
            || gen_stat[c].timer == $past(gen_stat[c].timer) + 8'h1
      ) else $error("timer moved by more than one count");

      chk_tick_single: assert property ( // [R16]
        @(posedge pclk) disable iff (!presetn)
        gen_stat[c].tick |=> !gen_stat[c].tick
      ) else $error("generator tick lasted two cycles");

      chk_status_readback: assert property ( // [R04]
        @(posedge pclk) disable iff (!presetn)
        (s_setup_read and (paddr == byte_addr(STATUS_IDX[c])))
        |=> prdata == {23'h0, $past(gen_stat[c].level), $past(gen_stat[c].timer)}
      ) else $error("status readback differs from generator state");

      chk_async_src_write: assert property ( // [R02]
        @(posedge pclk) disable iff (!presetn)
        (s_access_done and pwrite and pstrb[0]
         and (paddr == byte_addr(ASYNC_MODE_IDX[c])))
        |=> st_reg.async_src[c] == $past(pwdata[SRC_SEL_BIT])
      ) else $error("async source bit did not take written value");

      chk_sync_src_write: assert property ( // [R02]
        @(posedge pclk) disable iff (!presetn)
        (s_access_done and pwrite and pstrb[0]
         and (paddr == byte_addr(SYNC_MODE_IDX[c])))
        |=> st_reg.sync_src[c] == $past(pwdata[SRC_SEL_BIT])
      ) else $error("sync source bit did not take written value");

      chk_uart_follows_gen: assert property ( // [R06]
        @(posedge pclk) disable iff (!presetn)
        st_reg.async_src[c]
        |=> shift_clk[c].uart_tick == $past(gen_stat[c].tick)
      ) else $error("uart tick does not follow generator");

      chk_csi_raw_clock: assert property ( // [R01]
        @(posedge pclk) disable iff (!presetn)
        !st_reg.sync_src[c] |=> shift_clk[c].csi_tick
      ) else $error("raw clock source gave no csi tick");
    end
  endgenerate
endmodule

// [dv/serial_unit_model.sv]
// Purpose: stand-in for the async and clocked serial units fed by the shift clocks
// Assumes: ticks are one-cycle enables sampled on pclk
// Notes: only measures tick spacing and counts csi ticks; it never writes rate settings itself
`timescale 1ns/1ps
module serial_unit_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // shift clocks from the generators
  input wire baud_pkg::shift_clk_t [baud_pkg::CHANNELS-1:0] shift_clk,
  // measured spacing
  output int uart_gap [2],
  output int csi_gap [2],
  output int csi_cnt [2],
  output int csi_last [2],
  output int cyc
);
  import baud_pkg::*;
  int uart_last [2];
  // both units of a channel are timed by the same counter, so rates compare directly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc <= 0;
      for (int c = 0; c < 2; c++) begin
        uart_gap[c] <= 0;
        csi_gap[c] <= 0;
        csi_cnt[c] <= 0;
        csi_last[c] <= 0;
        uart_last[c] <= 0;
      end
    end else begin
      cyc <= cyc + 1;
      for (int c = 0; c < 2; c++) begin
        if (shift_clk[c].uart_tick === 1'b1) begin
          uart_gap[c] <= cyc - uart_last[c];
          uart_last[c] <= cyc;
        end
        if (shift_clk[c].csi_tick === 1'b1) begin
          csi_gap[c] <= cyc - csi_last[c];
          csi_last[c] <= cyc;
          csi_cnt[c] <= csi_cnt[c] + 1;
        end
      end
    end
  end
endmodule

// [dv/serial_baud_rate_generator_tb.sv]
// Purpose: self-checking bench for the two baud rate generators
// Assumes: apb slave answers whenever pready is seen high
// Notes: first interval after a setting change is irregular, so it is skipped
`timescale 1ns/1ps
module serial_baud_rate_generator_tb;
  import baud_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0] pstrb;
  shift_clk_t [CHANNELS-1:0] shift_clk;
  int uart_gap [2], csi_gap [2], csi_cnt [2], csi_last [2], cyc;
  int fails = 0;
  int comparisons = 0;
  int j, t, g;

  serial_baud_rate_generator dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .shift_clk(shift_clk));
  serial_unit_model far (.pclk(pclk), .presetn(presetn), .shift_clk(shift_clk),
    .uart_gap(uart_gap), .csi_gap(csi_gap), .csi_cnt(csi_cnt), .csi_last(csi_last),
    .cyc(cyc));

  initial begin
    pclk = 0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // upper strobe lanes are random: only lane 0 carries a register
  task automatic wr(input logic [31:0] idx, input logic [31:0] d);
    apb(1'b1, byte_addr(idx), d, 4'h1 | 4'($urandom_range(0, 15)));
  endtask

  task automatic rdc(input logic [31:0] idx, input string what, input logic [31:0] exp);
    apb(1'b0, byte_addr(idx), 32'h0, 4'h0);
    chk(what, exp, rd);
  endtask

  task automatic wait_ticks(input int c, input int n);
    int s, k;
    s = csi_cnt[c];
    k = 0;
    while (csi_cnt[c] < s + n && k < 30000) begin
      @(posedge pclk);
      k++;
    end
    if (k == 30000) chk("tick wait", 1, 0);
  endtask

  // reference divide: compare value times prescaled period, 1xx saturates at /32
  function automatic int gap_of(input int jv, input int sel);
    int m;
    m = (sel > 3) ? 4 : sel;
    return ((jv == 0) ? 256 : jv) * (2 << m);
  endfunction

  initial begin
    #(25 * 80000);
    fails++;
    conclude();
  end

  initial begin
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    pstrb = 0;
    void'($urandom(32'h277b08ff));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    for (int c = 0; c < 2; c++) begin
      chk("raw csi gap", 1, csi_gap[c]);
      chk("raw uart gap", 1, uart_gap[c]);
      rdc(PRESCALE_IDX[c], "prescale reset", 32'h00);
      rdc(COMPARE_IDX[c], "compare reset", 32'(COMPARE_RST));
    end
    apb(1'b0, 32'h00000010, 32'h0, 4'h0);
    chk("unmapped err", 1, err);
    chk("unmapped data", 0, rd);
    wr(PRESCALE_IDX[0], 32'hffffffff);
    rdc(PRESCALE_IDX[0], "prescale mask", 32'h87);
    wr(COMPARE_IDX[0], 32'h000000a5);
    apb(1'b1, byte_addr(COMPARE_IDX[0]), 32'h12, 4'he);
    rdc(COMPARE_IDX[0], "compare lane", 32'ha5);
    for (int c = 0; c < 2; c++) begin
      wr(ASYNC_MODE_IDX[c], 32'h1);
      wr(SYNC_MODE_IDX[c], 32'h1);
      for (int s = 0; s < 8; s++) begin
        j = (s == 0) ? 0 : $urandom_range(1, 16);
        g = gap_of(j, s);
        wr(COMPARE_IDX[c], j);
        wr(PRESCALE_IDX[c], 32'h80 | s);
        wait_ticks(c, 3);
        chk("csi gap", g, csi_gap[c]);
        chk("uart gap", g, uart_gap[c]);
      end
      wr(SYNC_MODE_IDX[c], 32'h0);
      repeat (3 * g) @(posedge pclk);
      chk("sync raw gap", 1, csi_gap[c]);
      chk("async kept gap", g, uart_gap[c]);
      wr(SYNC_MODE_IDX[c], 32'h1);
      wr(COMPARE_IDX[c], 100);
      wr(PRESCALE_IDX[c], 32'h80);
      wait_ticks(c, 3);
      chk("rate error", 1, 32'(csi_gap[c] * 1000 >= 200 * 977 && csi_gap[c] * 1000 <= 200 * 1023));
      repeat (150) @(posedge pclk);
      wr(COMPARE_IDX[c], 100);
      t = cyc;
      wait_ticks(c, 1);
      chk("clear on write", 1, 32'(csi_last[c] - t > 150));
      wr(PRESCALE_IDX[c], 32'h07);
      t = csi_cnt[c];
      repeat (600) @(posedge pclk);
      chk("stopped ticks", t, csi_cnt[c]);
      rdc(STATUS_IDX[c], "stopped timer", 32'h0);
      chk("stopped level", 0, 32'(shift_clk[c].rate_level));
    end
    conclude();
  end
endmodule
